// File: hdl/tw_pkg.sv
package tw_pkg;

  // =====================================================================
  // Bus state encodings reported to software.
  // =====================================================================
  localparam logic [1:0] BUS_UNKNOWN = 2'h0;
  localparam logic [1:0] BUS_IDLE    = 2'h1;
  localparam logic [1:0] BUS_OWNER   = 2'h2;
  localparam logic [1:0] BUS_BUSY    = 2'h3;

  // =====================================================================
  // Slave command codes.
  // =====================================================================
  localparam logic [1:0] CMD_NONE     = 2'h0;
  localparam logic [1:0] CMD_RSVD     = 2'h1;
  localparam logic [1:0] CMD_COMPLETE = 2'h2;
  localparam logic [1:0] CMD_RESPONSE = 2'h3;

  // =====================================================================
  // Link event bit positions and byte framing.
  // =====================================================================
  localparam int EVT_START  = 0;
  localparam int EVT_RSTART = 1;
  localparam int EVT_STOP   = 2;
  localparam int EVT_ADDR   = 3;
  localparam int EVT_BYTE   = 4;
  localparam int EVT_NUM    = 5;
  localparam logic [3:0] BIT_LAST_DATA = 4'h7;
  localparam logic [3:0] BIT_ACK       = 4'h8;

  // =====================================================================
  // Bus timeout, in microseconds and in system clock cycles.
  // =====================================================================
  localparam int SYS_CLK_MHZ  = 20;
  localparam int TIMEOUT_US   = 100;
  localparam int TIMEOUT_CYC  = TIMEOUT_US * SYS_CLK_MHZ;
  localparam int TIMEOUT_W    = 12;

  // =====================================================================
  // Values after reset.
  // =====================================================================
  localparam logic [6:0] RST_SLAVE_ADDR   = 7'h00;
  localparam logic       RST_SDA_HOLD_SEL = 1'b0;
  localparam logic [7:0] RST_SECOND_PORT  = 8'h00;

endpackage

// File: hdl/tw_evt_sync.sv
`timescale 1ns/1ps

module tw_evt_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] lvl_o,
  output logic      [W-1:0] pls_o
);

  // =====================================================================
  // Two-flop synchroniser per bit, with an edge pulse after the second flop.
  // =====================================================================
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] prev_q;

  genvar gi;
  generate
    for (gi = 0; gi < W; gi++)
    begin : g_bit
      always_ff @(posedge clk_i)
      begin
        if (!rst_n_i)
        begin
          meta_q[gi] <= 1'b0;
          sync_q[gi] <= 1'b0;
          prev_q[gi] <= 1'b0;
        end
        else
        begin
          meta_q[gi] <= async_i[gi];
          sync_q[gi] <= meta_q[gi];
          prev_q[gi] <= sync_q[gi];
        end
      end
      assign pls_o[gi] = sync_q[gi] ^ prev_q[gi];
    end
  endgenerate

  assign lvl_o = sync_q;

endmodule

// File: hdl/tw_link_mon.sv
`timescale 1ns/1ps

module tw_link_mon (
  input  wire logic                    clk_link_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    scl_i,
  input  wire logic                    sda_i,
  output logic [tw_pkg::EVT_NUM-1:0]   evt_tgl_o,
  output logic [7:0]                   addr_byte_o,
  output logic                         bus_busy_o,
  output logic                         scl_low_o
);

  // =====================================================================
  // Reset and pin synchronisers in the link domain.
  // =====================================================================
  logic       rst_meta_q;
  logic       rst_q;
  logic       scl_m_q;
  logic       scl_s_q;
  logic       scl_p_q;
  logic       sda_m_q;
  logic       sda_s_q;
  logic       sda_p_q;

  always_ff @(posedge clk_link_i)
  begin
    rst_meta_q <= rst_n_i;
    rst_q      <= rst_meta_q;
    scl_m_q    <= scl_i;
    scl_s_q    <= scl_m_q;
    scl_p_q    <= scl_s_q;
    sda_m_q    <= sda_i;
    sda_s_q    <= sda_m_q;
    sda_p_q    <= sda_s_q;
  end

  // =====================================================================
  // Bus condition detection and byte framing.
  // =====================================================================
  wire start_w = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  wire stop_w  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;
  wire rise_w  = scl_s_q & ~scl_p_q;

  logic                       busy_q;
  logic                       first_q;
  logic [3:0]                 bit_cnt_q;
  logic [7:0]                 shift_q;
  logic [7:0]                 addr_q;
  logic [tw_pkg::EVT_NUM-1:0] tgl_q;

  wire [7:0] byte_w = {shift_q[6:0], sda_s_q};

  always_ff @(posedge clk_link_i)
  begin
    if (!rst_q)
    begin
      busy_q    <= 1'b0;
      first_q   <= 1'b0;
      bit_cnt_q <= 4'h0;
      shift_q   <= 8'h00;
      addr_q    <= 8'h00;
      tgl_q     <= '0;
    end
    else if (start_w)
    begin
      busy_q    <= 1'b1;
      first_q   <= 1'b1;
      bit_cnt_q <= 4'h0;
      if (busy_q)
        tgl_q[tw_pkg::EVT_RSTART] <= ~tgl_q[tw_pkg::EVT_RSTART];
      else
        tgl_q[tw_pkg::EVT_START] <= ~tgl_q[tw_pkg::EVT_START];
    end
    else if (stop_w)
    begin
      busy_q                  <= 1'b0;
      first_q                 <= 1'b0;
      tgl_q[tw_pkg::EVT_STOP] <= ~tgl_q[tw_pkg::EVT_STOP];
    end
    else if (rise_w && busy_q)
    begin
      shift_q   <= byte_w;
      bit_cnt_q <= (bit_cnt_q == tw_pkg::BIT_ACK) ? 4'h0 : bit_cnt_q + 4'h1;
      if (bit_cnt_q == tw_pkg::BIT_LAST_DATA)
      begin
        first_q <= 1'b0;
        if (first_q)
        begin
          addr_q                  <= byte_w;
          tgl_q[tw_pkg::EVT_ADDR] <= ~tgl_q[tw_pkg::EVT_ADDR];
        end
        else
          tgl_q[tw_pkg::EVT_BYTE] <= ~tgl_q[tw_pkg::EVT_BYTE];
      end
    end
  end

  assign evt_tgl_o   = tgl_q;
  assign addr_byte_o = addr_q;
  assign bus_busy_o  = busy_q;
  assign scl_low_o   = ~scl_s_q;

endmodule

// File: hdl/tw_flag_ctrl.sv
`timescale 1ns/1ps

module tw_flag_ctrl #(
  parameter int TIMEOUT_CYC = tw_pkg::TIMEOUT_CYC
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       clk_link_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            scl_o,
  output logic            scl_oe_n_o,
  output logic            sda_o,
  output logic            sda_oe_n_o,
  input  wire logic       enable_i,
  input  wire logic [6:0] slave_addr_i,
  input  wire logic       timeout_en_i,
  input  wire logic       ctrl_wr_i,
  input  wire logic       sda_hold_time_sel_i,
  input  wire logic       clr_stop_address_irq_flag_i,
  input  wire logic       clr_tx_collision_i,
  input  wire logic       data_wr_i,
  input  wire logic       cmd_valid_i,
  input  wire logic [1:0] cmd_i,
  input  wire logic       second_port_wr_i,
  input  wire logic [7:0] second_port_wdata_i,
  output logic            stop_address_irq_flag_o,
  output logic            data_irq_flag_o,
  output logic            clock_stretch_hold_o,
  output logic            tx_collision_o,
  output logic [1:0]      bus_state_o,
  output logic            transaction_dropped_o,
  output logic            addressed_o,
  output logic            sda_hold_time_sel_o,
  output logic [7:0]      second_port_rdata_o
);

  // =====================================================================
  // Link-domain monitor and crossings into the system domain.
  // =====================================================================
  logic [tw_pkg::EVT_NUM-1:0] evt_tgl;
  logic [tw_pkg::EVT_NUM-1:0] evt_pls;
  logic [7:0]                 addr_byte;
  logic                       link_busy;
  logic [0:0]                 lvl_sync;

  tw_link_mon u_link (
    .clk_link_i  (clk_link_i),
    .rst_n_i     (rst_n_i),
    .scl_i       (scl_i),
    .sda_i       (sda_i),
    .evt_tgl_o   (evt_tgl),
    .addr_byte_o (addr_byte),
    .bus_busy_o  (link_busy),
    .scl_low_o   ()
  );

  tw_evt_sync #(
    .W (tw_pkg::EVT_NUM)
  ) u_evt_sync (
    .clk_i   (clk_sys_i),
    .rst_n_i (rst_n_i),
    .async_i (evt_tgl),
    .lvl_o   (),
    .pls_o   (evt_pls)
  );

  tw_evt_sync #(
    .W (1)
  ) u_lvl_sync (
    .clk_i   (clk_sys_i),
    .rst_n_i (rst_n_i),
    .async_i (link_busy),
    .lvl_o   (lvl_sync),
    .pls_o   ()
  );

  // =====================================================================
  // Event decode.
  // =====================================================================
  wire ev_start_w  = evt_pls[tw_pkg::EVT_START];
  wire ev_rstart_w = evt_pls[tw_pkg::EVT_RSTART];
  wire ev_stop_w   = evt_pls[tw_pkg::EVT_STOP];
  wire ev_addr_w   = evt_pls[tw_pkg::EVT_ADDR];
  wire ev_byte_w   = evt_pls[tw_pkg::EVT_BYTE];
  wire bus_busy_w  = lvl_sync[0];

  // The address byte is held stable in the link domain from well before its
  // toggle arrives here until the next address, so it is read as a word.
  wire addr_hit_w  = (addr_byte[7:1] == slave_addr_i);

  // =====================================================================
  // Bus timeout counter.
  // =====================================================================
  localparam logic [tw_pkg::TIMEOUT_W-1:0] TO_LAST = tw_pkg::TIMEOUT_W'(TIMEOUT_CYC - 1);

  logic [tw_pkg::TIMEOUT_W-1:0] to_cnt_q;
  logic [tw_pkg::TIMEOUT_W-1:0] to_cnt_d;
  logic [1:0]                   bus_state_q;
  logic [1:0]                   bus_state_d;

  wire link_act_w  = |evt_pls;
  wire to_run_w    = timeout_en_i & enable_i & (bus_state_q != tw_pkg::BUS_IDLE);
  wire to_end_w    = to_run_w & (to_cnt_q == TO_LAST);
  wire to_fire_w   = to_end_w & ~link_act_w;

  assign to_cnt_d = (!to_run_w || link_act_w || to_fire_w) ? '0 : to_cnt_q + 1'b1;

  // =====================================================================
  // Transaction drop and address match.
  // =====================================================================
  logic drop_q;
  logic drop_d;
  logic addressed_q;
  logic addressed_d;

  // A START in the last counted cycle meets the timeout and loses its transaction.
  wire drop_hit_w  = to_end_w & (ev_start_w | ev_rstart_w);
  wire addr_ok_w   = enable_i & ev_addr_w & addr_hit_w & ~drop_q & ~drop_hit_w;
  wire byte_ok_w   = ev_byte_w & addressed_q & ~drop_q;

  assign drop_d = drop_hit_w ? 1'b1 :
                  (ev_start_w | ev_rstart_w | ev_stop_w) ? 1'b0 : drop_q;

  assign addressed_d = addr_ok_w ? 1'b1 :
                       (ev_start_w | ev_rstart_w | ev_stop_w | to_fire_w) ? 1'b0 : addressed_q;

  // =====================================================================
  // Bus state tracking.
  // =====================================================================
  always_comb
  begin
    bus_state_d = bus_state_q;
    if (!enable_i)
      bus_state_d = tw_pkg::BUS_UNKNOWN;
    else if (to_fire_w || ev_stop_w)
      bus_state_d = tw_pkg::BUS_IDLE;
    // The busy level only seeds the state after enable, so a timeout is not undone.
    else if (ev_start_w || ev_rstart_w || ((bus_state_q == tw_pkg::BUS_UNKNOWN) && bus_busy_w))
      bus_state_d = tw_pkg::BUS_BUSY;
    else if (bus_state_q == tw_pkg::BUS_UNKNOWN)
      bus_state_d = tw_pkg::BUS_IDLE;
  end

  // =====================================================================
  // Interrupt flags, clock-stretch hold and collision flag.
  // =====================================================================
  logic stop_address_irq_flag_q;
  logic stop_address_irq_flag_d;
  logic dif_q;
  logic dif_d;
  logic hold_q;
  logic hold_d;
  logic txcol_q;
  logic txcol_d;
  logic dif_clr_pend_q;

  wire cmd_resp_w  = cmd_valid_i & (cmd_i == tw_pkg::CMD_RESPONSE);
  wire cmd_done_w  = cmd_valid_i & (cmd_i == tw_pkg::CMD_COMPLETE);
  wire stop_address_irq_flag_set_w  = addr_ok_w | (ev_stop_w & addressed_q);
  wire stop_address_irq_flag_clr_w  = clr_stop_address_irq_flag_i | cmd_done_w;
  wire txcol_set_w = data_wr_i & ~hold_q;

  // A set in the same cycle as a software clear wins, so the flag survives.
  assign stop_address_irq_flag_d = stop_address_irq_flag_set_w ? 1'b1 : (stop_address_irq_flag_clr_w ? 1'b0 : stop_address_irq_flag_q);

  // The response command takes effect on the data flag one cycle late.
  assign dif_d  = byte_ok_w ? 1'b1 : (dif_clr_pend_q ? 1'b0 : dif_q);

  // The hold is released by clearing the address flag, except when that clear
  // collides with a new address: then the hold stays and SCL stays low.
  assign hold_d = (addr_ok_w | byte_ok_w) ? 1'b1 :
                  (stop_address_irq_flag_clr_w | dif_clr_pend_q | ~addressed_d) ? 1'b0 : hold_q;

  // A first START or a software clear clears the collision flag; a repeated START does not.
  assign txcol_d = txcol_set_w ? 1'b1 :
                   (ev_start_w | clr_tx_collision_i) ? 1'b0 : txcol_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      to_cnt_q       <= '0;
      bus_state_q    <= tw_pkg::BUS_UNKNOWN;
      drop_q         <= 1'b0;
      addressed_q    <= 1'b0;
      stop_address_irq_flag_q         <= 1'b0;
      dif_q          <= 1'b0;
      hold_q         <= 1'b0;
      txcol_q        <= 1'b0;
      dif_clr_pend_q <= 1'b0;
    end
    else
    begin
      to_cnt_q       <= to_cnt_d;
      bus_state_q    <= bus_state_d;
      drop_q         <= drop_d;
      addressed_q    <= addressed_d;
      stop_address_irq_flag_q         <= stop_address_irq_flag_d;
      dif_q          <= dif_d;
      hold_q         <= hold_d;
      txcol_q        <= txcol_d;
      dif_clr_pend_q <= cmd_resp_w;
    end
  end

  // =====================================================================
  // Configuration: single-bit SDA hold and the absent second unit.
  // =====================================================================
  logic       sda_hold_q;
  logic [7:0] second_port_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      sda_hold_q <= tw_pkg::RST_SDA_HOLD_SEL;
    else if (ctrl_wr_i)
      sda_hold_q <= sda_hold_time_sel_i;
  end

  // Writes aimed at the second unit land nowhere and it always reads as zero.
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i || second_port_wr_i || (second_port_wdata_i != 8'h00))
      second_port_q <= tw_pkg::RST_SECOND_PORT;
    else
      second_port_q <= tw_pkg::RST_SECOND_PORT;
  end

  // =====================================================================
  // Registered outputs.
  // =====================================================================
  logic       scl_oe_n_q;
  logic [1:0] bus_state_out_q;
  logic       stop_address_irq_flag_out_q;
  logic       dif_out_q;
  logic       hold_out_q;
  logic       txcol_out_q;
  logic       drop_out_q;
  logic       addressed_out_q;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      scl_oe_n_q      <= 1'b1;
      bus_state_out_q <= tw_pkg::BUS_UNKNOWN;
      stop_address_irq_flag_out_q      <= 1'b0;
      dif_out_q       <= 1'b0;
      hold_out_q      <= 1'b0;
      txcol_out_q     <= 1'b0;
      drop_out_q      <= 1'b0;
      addressed_out_q <= 1'b0;
    end
    else
    begin
      scl_oe_n_q      <= ~hold_d;
      bus_state_out_q <= bus_state_d;
      stop_address_irq_flag_out_q      <= stop_address_irq_flag_d;
      dif_out_q       <= dif_d;
      hold_out_q      <= hold_d;
      txcol_out_q     <= txcol_d;
      drop_out_q      <= drop_d;
      addressed_out_q <= addressed_d;
    end
  end

  assign scl_o                   = 1'b0;
  assign scl_oe_n_o              = scl_oe_n_q;
  assign sda_o                   = 1'b0;
  assign sda_oe_n_o              = 1'b1;
  assign stop_address_irq_flag_o = stop_address_irq_flag_out_q;
  assign data_irq_flag_o         = dif_out_q;
  assign clock_stretch_hold_o    = hold_out_q;
  assign tx_collision_o          = txcol_out_q;
  assign bus_state_o             = bus_state_out_q;
  assign transaction_dropped_o   = drop_out_q;
  assign addressed_o             = addressed_out_q;
  assign sda_hold_time_sel_o     = sda_hold_q;
  assign second_port_rdata_o     = second_port_q;

endmodule

// File: tb/tw_flag_ctrl_properties.sv
`timescale 1ns/1ps

module tw_flag_ctrl_chk (
  input wire logic       clk_sys_i,
  input wire logic       rst_n_i,
  input wire logic       enable_i,
  input wire logic       timeout_en_i,
  input wire logic       ctrl_wr_i,
  input wire logic       sda_hold_time_sel_i,
  input wire logic       clr_stop_address_irq_flag_i,
  input wire logic       clr_tx_collision_i,
  input wire logic       data_wr_i,
  input wire logic       cmd_valid_i,
  input wire logic [1:0] cmd_i,
  input wire logic       scl_oe_n_o,
  input wire logic       stop_address_irq_flag_o,
  input wire logic       data_irq_flag_o,
  input wire logic       clock_stretch_hold_o,
  input wire logic       tx_collision_o,
  input wire logic [1:0] bus_state_o,
  input wire logic       transaction_dropped_o,
  input wire logic       sda_hold_time_sel_o,
  input wire logic [7:0] second_port_rdata_o
);
  // ==========
  // Flag, hold and status properties.
  // ==========
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  a_hold_drives_scl: assert property (clock_stretch_hold_o == !scl_oe_n_o)
    else $error("hold and SCL drive disagree");
  a_race_keeps_hold: assert property (
    $rose(stop_address_irq_flag_o) && $past(clr_stop_address_irq_flag_i) |-> clock_stretch_hold_o)
    else $error("hold lost on clear race");
  a_resp_flag_delay: assert property (
    cmd_valid_i && cmd_i == tw_pkg::CMD_RESPONSE && data_irq_flag_o |=> data_irq_flag_o ##1 !data_irq_flag_o)
    else $error("data flag clear not one cycle late");
  a_resp_hold_free: assert property (
    cmd_valid_i && cmd_i == tw_pkg::CMD_RESPONSE && data_irq_flag_o && !stop_address_irq_flag_o
    |=> ##1 !clock_stretch_hold_o)
    else $error("hold not released by response");
  a_coll_on_write: assert property (data_wr_i && !clock_stretch_hold_o |=> tx_collision_o)
    else $error("collision not flagged");
  a_coll_sw_clear: assert property (clr_tx_collision_i && !data_wr_i |=> !tx_collision_o)
    else $error("collision clear ignored");
  a_drop_needs_timeout: assert property ($rose(transaction_dropped_o) |-> $past(timeout_en_i))
    else $error("drop without timeout enabled");
  a_disabled_state: assert property (!enable_i |=> bus_state_o == tw_pkg::BUS_UNKNOWN)
    else $error("bus state not unknown when disabled");
  a_state_legal: assert property (bus_state_o != tw_pkg::BUS_OWNER)
    else $error("unused bus state code");
  a_hold_sel_load: assert property (ctrl_wr_i |=> sda_hold_time_sel_o == $past(sda_hold_time_sel_i))
    else $error("hold select not loaded");
  a_no_second_port: assert property (second_port_rdata_o == 8'h00)
    else $error("second port reads non zero");
endmodule

bind tw_flag_ctrl tw_flag_ctrl_chk u_chk (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .enable_i(enable_i),
  .timeout_en_i(timeout_en_i), .ctrl_wr_i(ctrl_wr_i), .sda_hold_time_sel_i(sda_hold_time_sel_i),
  .clr_stop_address_irq_flag_i(clr_stop_address_irq_flag_i), .clr_tx_collision_i(clr_tx_collision_i),
  .data_wr_i(data_wr_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .scl_oe_n_o(scl_oe_n_o),
  .stop_address_irq_flag_o(stop_address_irq_flag_o), .data_irq_flag_o(data_irq_flag_o),
  .clock_stretch_hold_o(clock_stretch_hold_o), .tx_collision_o(tx_collision_o), .bus_state_o(bus_state_o),
  .transaction_dropped_o(transaction_dropped_o), .sda_hold_time_sel_o(sda_hold_time_sel_o),
  .second_port_rdata_o(second_port_rdata_o));

// File: tb/tw_bus_master.sv
`timescale 1ns/1ps

module tw_bus_master (
  input  wire logic clk_link_i,
  input  wire logic scl_i,
  output logic      scl_o,
  output logic      sda_o
);
  // ==========
  // Open-drain drive levels; a released line reads high via its pull-up.
  // ==========
  initial
  begin
    scl_o = 1'h1;
    sda_o = 1'h1;
  end

  task automatic wait_link(input int n);
    repeat (n) @(posedge clk_link_i);
  endtask

  // SCL rise is held off while the slave stretches the clock.
  task automatic rise_scl();
    scl_o <= 1'h1;
    for (int k = 0; k < 2000 && scl_i !== 1'h1; k++) wait_link(1);
    wait_link(2);
  endtask

  // From a busy bus this frees both lines first, giving a repeated START.
  task automatic do_start();
    sda_o <= 1'h1;
    wait_link(2);
    rise_scl();
    sda_o <= 1'h0;
    wait_link(2);
    scl_o <= 1'h0;
    wait_link(1);
  endtask

  task automatic do_bit(input logic b);
    sda_o <= b;
    wait_link(2);
    rise_scl();
    scl_o <= 1'h0;
    wait_link(1);
  endtask

  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) do_bit(b[i]);
  endtask

  task automatic do_stop();
    sda_o <= 1'h0;
    wait_link(2);
    rise_scl();
    sda_o <= 1'h1;
    wait_link(2);
  endtask
endmodule

// File: tb/testbench.sv
`timescale 1ns/1ps

module testbench;
  // A multiple of eight system cycles lines the timeout up with whole link periods.
  localparam int         TOUT     = 24;
  localparam logic [6:0] OWN_ADDR = 7'h5A;

  logic       clk_sys_i = 1'h0;
  logic       clk_link_i = 1'h0;
  logic       rst_n_i = 1'h0;
  logic       enable_i = 1'h1;
  logic       timeout_en_i = 1'h0;
  logic       ctrl_wr_i = 1'h0;
  logic       sda_hold_time_sel_i = 1'h0;
  logic       clr_stop_address_irq_flag_i = 1'h0;
  logic       clr_tx_collision_i = 1'h0;
  logic       data_wr_i = 1'h0;
  logic       cmd_valid_i = 1'h0;
  logic [1:0] cmd_i = 2'h0;
  logic       second_port_wr_i = 1'h0;
  logic [7:0] second_port_wdata_i = 8'h00;
  logic       scl_o, scl_oe_n_o, sda_o, sda_oe_n_o, m_scl, m_sda;
  logic       stop_address_irq_flag_o, data_irq_flag_o, clock_stretch_hold_o, tx_collision_o;
  logic       transaction_dropped_o, addressed_o, sda_hold_time_sel_o;
  logic [1:0] bus_state_o;
  logic [7:0] second_port_rdata_o;
  wire        scl_bus = m_scl & (scl_oe_n_o | scl_o);
  wire        sda_bus = m_sda & (sda_oe_n_o | sda_o);
  int         errors = 0;
  int         n_compared = 0;

  always #25 clk_sys_i = ~clk_sys_i;
  always #40 clk_link_i = ~clk_link_i;

  tw_flag_ctrl #(.TIMEOUT_CYC(TOUT)) dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .clk_link_i(clk_link_i),
    .scl_i(scl_bus), .sda_i(sda_bus), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n_o), .sda_o(sda_o),
    .sda_oe_n_o(sda_oe_n_o), .enable_i(enable_i), .slave_addr_i(OWN_ADDR), .timeout_en_i(timeout_en_i),
    .ctrl_wr_i(ctrl_wr_i), .sda_hold_time_sel_i(sda_hold_time_sel_i),
    .clr_stop_address_irq_flag_i(clr_stop_address_irq_flag_i), .clr_tx_collision_i(clr_tx_collision_i),
    .data_wr_i(data_wr_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .second_port_wr_i(second_port_wr_i),
    .second_port_wdata_i(second_port_wdata_i), .stop_address_irq_flag_o(stop_address_irq_flag_o),
    .data_irq_flag_o(data_irq_flag_o), .clock_stretch_hold_o(clock_stretch_hold_o),
    .tx_collision_o(tx_collision_o), .bus_state_o(bus_state_o), .transaction_dropped_o(transaction_dropped_o),
    .addressed_o(addressed_o), .sda_hold_time_sel_o(sda_hold_time_sel_o),
    .second_port_rdata_o(second_port_rdata_o));

  tw_bus_master m (.clk_link_i(clk_link_i), .scl_i(scl_bus), .scl_o(m_scl), .sda_o(m_sda));

  // ==========
  // Helpers.
  // ==========
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic wait_hold();
    for (int k = 0; k < 400 && clock_stretch_hold_o !== 1'h1; k++) step(1);
  endtask

  // Pulses {data write, collision clear, stop flag clear} for one cycle.
  task automatic sw(input logic [2:0] p);
    @(posedge clk_sys_i);
    {data_wr_i, clr_tx_collision_i, clr_stop_address_irq_flag_i} <= p;
    @(posedge clk_sys_i);
    {data_wr_i, clr_tx_collision_i, clr_stop_address_irq_flag_i} <= 3'h0;
    #1;
  endtask

  task automatic cmd(input logic [1:0] c);
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'h1;
    cmd_i <= c;
    @(posedge clk_sys_i);
    cmd_valid_i <= 1'h0;
    #1;
  endtask

  task automatic end_of_test();
    if (errors == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========
  // Scenarios.
  // ==========
  task automatic t_reset_and_config();
    step(3);
    chk(bus_state_o, tw_pkg::BUS_IDLE);
    chk({stop_address_irq_flag_o, data_irq_flag_o, clock_stretch_hold_o, tx_collision_o, scl_oe_n_o}, 8'h01);
    @(posedge clk_sys_i);
    {ctrl_wr_i, sda_hold_time_sel_i, second_port_wr_i, second_port_wdata_i} <= {3'h7, 8'hFF};
    @(posedge clk_sys_i);
    {ctrl_wr_i, second_port_wr_i, enable_i} <= 3'h0;
    step(2);
    chk(sda_hold_time_sel_o, 8'h01);
    chk(second_port_rdata_o, 8'h00);
    chk(bus_state_o, tw_pkg::BUS_UNKNOWN);
    @(posedge clk_sys_i);
    enable_i <= 1'h1;
    step(3);
  endtask

  task automatic t_address_and_response();
    m.do_start();
    m.send_byte({OWN_ADDR, 1'h0});
    wait_hold();
    chk({stop_address_irq_flag_o, scl_oe_n_o, addressed_o, bus_state_o}, 8'h17);
    cmd(tw_pkg::CMD_COMPLETE);
    step(1);
    chk({stop_address_irq_flag_o, clock_stretch_hold_o}, 8'h00);
    m.do_bit(1'h1);
    m.send_byte(8'hC3);
    wait_hold();
    chk(data_irq_flag_o, 8'h01);
    cmd(tw_pkg::CMD_RESPONSE);
    chk(data_irq_flag_o, 8'h01);
    step(1);
    chk({data_irq_flag_o, clock_stretch_hold_o, scl_oe_n_o}, 8'h01);
    m.do_bit(1'h1);
    m.do_stop();
    step(12);
    chk({stop_address_irq_flag_o, bus_state_o}, 8'h05);
    sw(3'h1);
    chk(stop_address_irq_flag_o, 8'h00);
  endtask

  task automatic t_collision();
    sw(3'h4);
    chk(tx_collision_o, 8'h01);
    m.do_start();
    step(12);
    chk(tx_collision_o, 8'h00);
    sw(3'h4);
    m.do_start();
    step(12);
    chk(tx_collision_o, 8'h01);
    sw(3'h2);
    chk(tx_collision_o, 8'h00);
    m.do_stop();
    step(12);
  endtask

  task automatic t_clear_race();
    @(posedge clk_sys_i);
    clr_stop_address_irq_flag_i <= 1'h1;
    m.do_start();
    m.send_byte({OWN_ADDR, 1'h1});
    wait_hold();
    chk({stop_address_irq_flag_o, clock_stretch_hold_o, scl_oe_n_o}, 8'h06);
    @(posedge clk_sys_i);
    clr_stop_address_irq_flag_i <= 1'h0;
    step(4);
    // The clear still seen on the following edge releases the hold.
    chk({clock_stretch_hold_o, scl_oe_n_o}, 8'h01);
    cmd(tw_pkg::CMD_COMPLETE);
    m.do_bit(1'h1);
    m.do_stop();
    step(12);
    sw(3'h1);
  endtask

  task automatic t_timeout();
    @(posedge clk_sys_i);
    timeout_en_i <= 1'h1;
    m.do_start();
    // Fifteen link periods on, the repeated START lands in the last timeout cycle.
    m.wait_link(7);
    m.do_start();
    step(12);
    chk(transaction_dropped_o, 8'h01);
    step(3 * TOUT);
    chk(bus_state_o, tw_pkg::BUS_IDLE);
    @(posedge clk_sys_i);
    timeout_en_i <= 1'h0;
    m.do_stop();
    step(12);
  endtask

  initial
  begin
    repeat (6) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    t_reset_and_config();
    t_address_and_response();
    t_collision();
    t_clear_race();
    t_timeout();
    end_of_test();
  end

  initial
  begin
    #3000000;
    errors++;
    end_of_test();
  end
endmodule
